// File: bench/test_uart_line_modem_ctrl_status.sv
// Purpose: Self-checking bench for the line and modem control block.
// Assumes: Zero wait APB, clock enable held high.
// Notes: Datapath status is random except where a case pins it down.
`timescale 1ns/1ps
module test_uart_line_modem_ctrl_status;
	import ulmcs_pkg::*;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rnd = 1'b1, slow = 1'b0;
	logic [7:0] paddr = 8'h00, rx_head_data = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata;
	logic tx_serial = 1'b1, ir_tx_encoded = 1'b0, ir_rx_decoded = 1'b0, auto_rts_n = 1'b1, irq_request = 1'b0;
	logic pready, pslverr, rx_store, tx_resume, baud_tick, modem_irq_req, line_irq_req, sin, ir_rx;
	logic [3:0] want_n = 4'hf, modem_in_n;
	ulmcs_core_st_t core_st = '0;
	ulmcs_fmt_t fmt;
	ulmcs_pins_t pins;
	int n_mismatch = 0, samples_checked = 0;
	always #10 clock = ~clock;
	ulmcs_top dut (.clock, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.core_st, .rx_head_data, .tx_serial, .ir_tx_encoded, .ir_rx_decoded, .auto_rts_n, .irq_request, .fmt,
		.tx_data(), .tx_write(), .rx_read(), .rx_store, .tx_resume, .baud_tick, .rx_serial(), .ir_rx_to_dec(),
		.modem_irq_req, .line_irq_req, .modem_in_n, .sin, .ir_rx, .pins);
	ulmcs_modem_model u_modem (.clock, .want_n, .slow, .modem_in_n, .sin, .ir_rx);
	// Random datapath traffic while no case needs fixed status.
	always @(posedge clock) if (rnd) begin
		core_st <= 11'($urandom);
		{rx_head_data, tx_serial, ir_tx_encoded, ir_rx_decoded, auto_rts_n, irq_request} <= 13'($urandom);
	end
	// ========================================
	// Tasks
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// Request is held until pready is seen high; the wait is bounded.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q, output logic e);
		int n;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge clock);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n == 20) begin
			n_mismatch++;
			wrap_up();
		end
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] x, input string nm);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 8'h00, q, e);
		check(nm, q, x);
	endtask : rdc
	// One completed character; st is whether it must be stored.
	task automatic rx_char(input ulmcs_core_st_t s, input logic st);
		s.rx_done = 1'b1;
		@(posedge clock);
		core_st <= s;
		@(posedge clock);
		core_st.rx_done <= 1'b0;
		#1 check("store pulse", rx_store, st);
	endtask : rx_char
	function automatic logic [31:0] lsr_exp(input ulmcs_core_st_t s, input logic ovr);
		return {24'h0, s.fifo_err_any, s.tx_hold_empty & s.tx_shift_empty, s.tx_hold_empty, s.head_break,
			s.head_frame_err, s.head_parity_err, ovr, ~s.rx_fifo_empty};
	endfunction : lsr_exp
	// ========================================
	// Main sequence
	initial begin
		logic [31:0] q, cnt;
		logic e;
		logic [7:0] v;
		ulmcs_core_st_t s;
		void'($urandom(32'h4a93));
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		foreach (v[i]) if (i < 4) rdc((i == 3) ? 8'h14 : 8'(4 * (i + 1)), 32'h0, "reset value");
		apb(1'b0, 8'h20, 8'h00, q, e);
		check("unmapped error", e, 1'b1);
		wr(8'h08, 8'h80);
		rdc(8'h00, 32'h01, "divisor low reset");
		wr(8'h00, 8'h5a);
		wr(8'h04, 8'ha5);
		repeat (2) @(posedge clock);
		check("divisor", fmt.divisor, 16'ha55a);
		for (int i = 0; i < 8; i++) begin
			wr(8'h08, {2'h0, 3'(i), 3'h3});
			rdc(8'h04, 32'h0, "shared address");
			check("forced parity", {fmt.parity_forced, fmt.parity_forced & fmt.forced_value}, {i[2] & i[0],
				i[2] & i[0] & ~i[1]});
		end
		wr(8'h08, 8'h40);
		repeat (3) @(posedge clock);
		check("break line", {pins.sout, pins.ir_tx}, 2'h0);
		wr(8'h08, 8'h00);
		for (int i = 0; i < 8; i++) begin
			v = 8'($urandom) & 8'hef;
			if (i == 4) wr(8'h18, 8'h10);
			wr(8'h0c, v);
			rdc(8'h0c, {24'h0, i < 4 ? 3'h0 : v[7:5], v[4:0]}, "modem control");
			check("modem pins", {pins.terminal_ready_n, pins.request_send_n, pins.general_output_two_n,
				pins.irq_oe}, {~v[0], ~v[1], ~v[3], v[3]});
		end
		wr(8'h18, 8'h00);
		wr(8'h0c, 8'h00);
		rdc(8'h0c, {24'h0, v[7:5], 5'h0}, "enhanced bits latched");
		wr(8'h18, 8'h50);
		for (int p = 0; p < 2; p++) begin
			wr(8'h0c, p ? 8'h00 : 8'h80);
			repeat (8) @(posedge clock);
			cnt = 0;
			repeat (40) begin
				@(posedge clock);
				cnt += 32'(baud_tick);
			end
			check("baud ticks", cnt, p ? 32'h28 : 32'h0a);
		end
		wr(8'h18, 8'h10);
		wr(8'h04, 8'h08);
		rdc(8'h14, 32'h0, "modem idle");
		for (int k = 0; k < 8; k++) begin
			slow <= k[0];
			want_n[k % 4] <= ~want_n[k % 4];
			repeat (12) @(posedge clock);
			check("modem irq", modem_irq_req, k != 2);
			rdc(8'h14, {24'h0, ~want_n, (k == 2) ? 4'h0 : 4'h1 << (k % 4)}, "modem status");
			#1 check("modem irq cleared", modem_irq_req, 1'b0);
		end
		rdc(8'h14, {24'h0, ~want_n, 4'h0}, "deltas cleared");
		for (int i = 0; i < 2; i++) begin
			v = i ? 8'h14 : 8'h1f;
			wr(8'h0c, v);
			apb(1'b0, 8'h14, 8'h00, q, e);
			check("loop status", q[7:4], {v[3], v[2], v[0], v[1]});
			check("loop ring", q[6], v[2]);
		end
		wr(8'h0c, 8'h00);
		rnd <= 1'b0;
		@(posedge clock);
		// A stuck completion pulse from the random traffic would keep raising overrun.
		core_st <= '0;
		apb(1'b0, 8'h10, 8'h00, q, e);
		for (int k = 0; k < 6; k++) begin
			core_st <= 11'($urandom & 32'h3ff);
			repeat (2) @(posedge clock);
			rdc(8'h10, lsr_exp(core_st, 1'b0), "line status");
		end
		wr(8'h04, 8'h04);
		s = '0;
		s.rx_fifo_full = 1'b1;
		rx_char(s, 1'b0);
		check("line irq", line_irq_req, 1'b1);
		rdc(8'h10, lsr_exp(s, 1'b1), "overrun set");
		#1 check("line irq cleared", line_irq_req, 1'b0);
		rdc(8'h10, lsr_exp(s, 1'b0), "overrun cleared");
		s = '0;
		s.rx_is_break = 1'b1;
		rx_char(s, 1'b1);
		rx_char(s, 1'b0);
		s.rx_is_break = 1'b0;
		rx_char(s, 1'b1);
		wr(8'h0c, 8'h20);
		s.rx_is_flow_char = 1'b1;
		rx_char(s, 1'b0);
		check("resume", tx_resume, 1'b1);
		wrap_up();
	end
endmodule : test_uart_line_modem_ctrl_status
bind ulmcs_top ulmcs_checker u_chk (.clock, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .core_st,
	.auto_rts_n, .fmt, .baud_tick, .modem_irq_req, .line_irq_req, .modem_in_n, .pins);

// File: bench/ulmcs_assertions.sv
// Purpose: Checker for the line and modem control block.
// Assumes: Shadow copies are built from APB writes seen at the ports.
// Notes: Bound to ulmcs_top from the testbench top file.
`timescale 1ns/1ps
module ulmcs_checker (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// APB
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	// Datapath and line
	input wire ulmcs_pkg::ulmcs_core_st_t core_st,
	input wire logic auto_rts_n,
	input wire ulmcs_pkg::ulmcs_fmt_t fmt,
	input wire logic baud_tick,
	input wire logic modem_irq_req,
	input wire logic line_irq_req,
	input wire logic [3:0] modem_in_n,
	input wire ulmcs_pkg::ulmcs_pins_t pins
);
	import ulmcs_pkg::*;
	// ========================================
	// Shadow registers
	logic [7:0] lcr_sh, mcr_sh, ier_sh, efr_sh;
	logic [3:0] quiet, gap;
	logic wr, rd_msr, rd_lsr;
	assign wr = psel && penable && pwrite && ce;
	assign rd_msr = psel && penable && !pwrite && ce && paddr == 8'h14;
	assign rd_lsr = psel && penable && !pwrite && ce && paddr == 8'h10;
	// Quiet counts cycles since a modem pin or control change, so delta clears are judged only once settled.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			lcr_sh <= 8'h00;
			mcr_sh <= 8'h00;
			ier_sh <= 8'h00;
			efr_sh <= 8'h00;
			quiet <= 4'h0;
			gap <= 4'h0;
		end else begin
			if (wr && paddr == 8'h08) lcr_sh <= pwdata[7:0];
			if (wr && paddr == 8'h04 && !lcr_sh[7]) ier_sh <= pwdata[7:0];
			if (wr && paddr == 8'h18) efr_sh <= pwdata[7:0];
			if (wr && paddr == 8'h0c) mcr_sh <= efr_sh[4] ? pwdata[7:0] : {mcr_sh[7:5], pwdata[4:0]};
			quiet <= (modem_in_n != $past(modem_in_n) || (wr && paddr == 8'h0c)) ? 4'h0 : quiet + 4'(quiet != 4'hf);
			gap <= baud_tick ? 4'h0 : gap + 4'(gap != 4'hf);
		end
	end
	// ========================================
	// Properties
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	a_break_space: assert property (lcr_sh[6] && !mcr_sh[4] |=> !pins.sout && !pins.ir_tx)
		else $error("break left serial output high");
	a_dtr_inverse: assert property (!mcr_sh[4] |=> pins.terminal_ready_n != $past(mcr_sh[0]))
		else $error("terminal ready pin wrong");
	a_rts_inverse: assert property (!mcr_sh[4] && !efr_sh[6] |=> pins.request_send_n != $past(mcr_sh[1]))
		else $error("request to send pin wrong");
	a_rts_auto: assert property (!mcr_sh[4] && efr_sh[6] |=> pins.request_send_n == $past(auto_rts_n))
		else $error("auto request to send not followed");
	a_out2_irq_en: assert property (!mcr_sh[4] |=> pins.general_output_two_n != $past(mcr_sh[3])
		&& pins.irq_oe == $past(mcr_sh[3]))
		else $error("output two or interrupt enable wrong");
	a_loop_idle: assert property (mcr_sh[4] |=> pins.terminal_ready_n && pins.request_send_n)
		else $error("modem outputs active in loopback");
	a_forced_parity: assert property ($stable(lcr_sh) && lcr_sh[3] |-> fmt.parity_forced == lcr_sh[5]
		&& (!lcr_sh[5] || fmt.forced_value == !lcr_sh[4]))
		else $error("forced parity format wrong");
	a_delta_irq: assert property (ier_sh[3] && !mcr_sh[4] && modem_in_n[1:0] != $past(modem_in_n[1:0])
		|-> ##[1:4] modem_irq_req)
		else $error("modem change gave no interrupt request");
	a_msr_clear: assert property (rd_msr && quiet > 4'h6 && !mcr_sh[4] |=> !modem_irq_req)
		else $error("modem status read left request");
	a_lsr_clear: assert property (rd_lsr && !core_st.rx_done && !$past(core_st.rx_done) |=> !line_irq_req)
		else $error("line status read left request");
	a_baud_full: assert property (!$past(rst) && !mcr_sh[7] && !$past(mcr_sh[7]) |-> baud_tick)
		else $error("baud tick missing undivided");
	a_baud_quarter: assert property (mcr_sh[7] && $past(mcr_sh[7], 8) && baud_tick |-> gap == 4'h3)
		else $error("baud tick spacing not four");
	c_break: cover property (lcr_sh[6] ##1 !pins.sout);
	c_msr_read: cover property (rd_msr && modem_irq_req);
	c_presc: cover property (mcr_sh[7] && baud_tick);
endmodule : ulmcs_checker

// File: bench/ulmcs_modem_model.sv
// Purpose: Remote modem driving the modem and serial input pins.
// Assumes: The bench sets the wanted modem levels.
// Notes: Serial line is driven at mark from the start; infrared input idles low.
`timescale 1ns/1ps
module ulmcs_modem_model (
	// Clock and commands
	input wire logic clock,
	input wire logic [3:0] want_n,
	input wire logic slow,
	// Pins towards the channel
	output logic [3:0] modem_in_n,
	output logic sin,
	output logic ir_rx
);
	logic [2:0] lag;
	initial begin
		modem_in_n = 4'hf;
		sin = 1'b1;
		ir_rx = 1'b0;
		lag = 3'h0;
	end
	// A slow modem settles its lines some cycles late, like a real one.
	always @(posedge clock) begin
		if (modem_in_n == want_n) lag <= 3'h0;
		else if (!slow || lag == 3'h4) modem_in_n <= want_n;
		else lag <= lag + 3'h1;
	end
endmodule : ulmcs_modem_model

// File: rtl/ulmcs_cfg.svh
// Purpose: Offsets, field positions, reset values and counts for the line and modem control block.
// Assumes: APB slave, one 32-bit word per register, data in the low byte.
// Notes: Included by the top module only.
//
// Behaviour
// [R1] Forced parity sends and checks 1 when even-select is 0, else 0.
// [R2] Break bit holds the serial output low until software clears it.
// [R3] Divisor-access bit steers shared addresses to the divisor registers.
// [R4] Terminal-ready pin is the inverse of its control bit.
// [R5] Request-to-send pin is the inverse of its bit outside auto flow control.
// [R6] Infrared receive polarity bit selects active-high or active-low encoded data.
// [R7] Output-2 bit enables interrupt output and drives general output low.
// [R8] Loopback bit loops the channel; output-1 bit drives ring status.
// [R9] Any-character resume restarts transmit; flow characters are not stored.
// [R10] Infrared enable routes serial data through encoder, transmit idles low.
// [R11] Prescaler bit divides the baud clock by four.
// [R12] Resume, infrared and prescaler bits change only with enhanced enable set.
// [R13] Data-ready shows a received character is waiting.
// [R14] Character completing into a full FIFO flags overrun and is not stored.
// [R15] Parity error follows the head receive character.
// [R16] Framing error follows the head receive character.
// [R17] Break is flagged and only one break character is stored.
// [R18] Holding-empty follows the holding register or empty transmit FIFO.
// [R19] Transmitter-empty is high only when holding and shift stages are empty.
// [R20] Global receive error is set while any FIFO character has an error.
// [R21] Modem input changes set delta flags and request a modem interrupt.
// [R22] Ring delta sets only when ringing ends.
// [R23] In loopback the modem status follows the control bits.
// [R24] Outside loopback the status bits are the complement of the pins.
// [R25] Reading modem status clears the modem interrupt request.
// [R26] Reading line status clears the line status interrupt request.
// [R27] Reading modem status clears the four delta flags.
// [R28] Reading line status clears overrun.
`ifndef ULMCS_CFG_SVH
`define ULMCS_CFG_SVH

// ========================================
// Register byte offsets
`define ULMCS_OFS_DATA 8'h00
`define ULMCS_OFS_IER 8'h04
`define ULMCS_OFS_LCR 8'h08
`define ULMCS_OFS_MCR 8'h0c
`define ULMCS_OFS_LSR 8'h10
`define ULMCS_OFS_MSR 8'h14
`define ULMCS_OFS_EFR 8'h18
`define ULMCS_OFS_FRAC 8'h1c

// ========================================
// Field positions
`define ULMCS_LCR_PEN 3
`define ULMCS_LCR_EVEN 4
`define ULMCS_LCR_FORCE 5
`define ULMCS_LCR_BREAK 6
`define ULMCS_LCR_DLAB 7
`define ULMCS_MCR_DTR 0
`define ULMCS_MCR_RTS 1
`define ULMCS_MCR_OUT1 2
`define ULMCS_MCR_OUT2 3
`define ULMCS_MCR_LOOP 4
`define ULMCS_MCR_XANY 5
`define ULMCS_MCR_IRDA 6
`define ULMCS_MCR_PRESC 7
`define ULMCS_EFR_ENH 4
`define ULMCS_EFR_ARTS 6
`define ULMCS_IER_LS 2
`define ULMCS_IER_MS 3

// ========================================
// Reset values and counts
`define ULMCS_RST_BYTE 8'h00
`define ULMCS_RST_DIV 8'h01
`define ULMCS_MCR_ENH_MASK 8'he0
`define ULMCS_PRESC_LAST 2'h3

`endif

// File: rtl/ulmcs_pkg.sv
// Purpose: Types shared by the line and modem control block.
// Assumes: Constants come from the cfg header.
// Notes: Modem vectors are ordered cd, ri, dsr, cts from bit 3 down.
package ulmcs_pkg;

	// ========================================
	// Register selector
	typedef enum logic [3:0] {
		SEL_NONE, SEL_RXTX, SEL_IER, SEL_DLL, SEL_DLM, SEL_LCR, SEL_MCR, SEL_LSR, SEL_MSR, SEL_EFR, SEL_FRAC
	} ulmcs_sel_t;

	// ========================================
	// Status levels and pulses from the receive and transmit datapath
	typedef struct packed {
		logic rx_done;
		logic rx_fifo_full;
		logic rx_fifo_empty;
		logic rx_is_break;
		logic rx_is_flow_char;
		logic head_parity_err;
		logic head_frame_err;
		logic head_break;
		logic fifo_err_any;
		logic tx_hold_empty;
		logic tx_shift_empty;
	} ulmcs_core_st_t;

	// ========================================
	// Frame format and controls sent to the datapath
	typedef struct packed {
		logic [1:0] word_len;
		logic stop_long;
		logic parity_en;
		logic parity_forced;
		logic forced_value;
		logic parity_even;
		logic [15:0] divisor;
		logic [7:0] divisor_fraction;
		logic xon_any;
		logic irda_en;
		logic loopback;
	} ulmcs_fmt_t;

	// ========================================
	// Line pins driven by the block
	typedef struct packed {
		logic sout;
		logic ir_tx;
		logic terminal_ready_n;
		logic request_send_n;
		logic general_output_two_n;
		logic irq_o;
		logic irq_oe;
	} ulmcs_pins_t;

	// ========================================
	// Whole block state
	typedef struct packed {
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] enhanced_feature_control;
		logic [7:0] interrupt_enable_control;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] divisor_fraction;
		logic [7:0] tx_data;
		logic tx_write;
		logic rx_read;
		logic [31:0] prdata;
		logic [3:0] modem_s1;
		logic [3:0] modem_s2;
		logic [3:0] modem_prev;
		logic [3:0] modem_delta;
		logic [1:0] sin_s1;
		logic [1:0] sin_s2;
		logic overrun;
		logic ls_pending;
		logic break_held;
		logic [1:0] presc_cnt;
		logic baud_tick;
		logic rx_store;
		logic tx_resume;
		logic rx_serial;
		logic ir_rx_to_dec;
		ulmcs_pins_t pins;
	} ulmcs_state_t;

endpackage : ulmcs_pkg

// File: rtl/ulmcs_top.sv
// Purpose: Line control, modem control, line status and modem status for one UART channel.
// Assumes: Datapath status arrives on the block clock; modem and serial pins are asynchronous.
// Notes: APB slave answers with pready whenever the clock enable is high.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "ulmcs_cfg.svh"

module ulmcs_top (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rst,
	input wire logic ce,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Datapath side
	input wire ulmcs_pkg::ulmcs_core_st_t core_st,
	input wire logic [7:0] rx_head_data,
	input wire logic tx_serial,
	input wire logic ir_tx_encoded,
	input wire logic ir_rx_decoded,
	input wire logic auto_rts_n,
	input wire logic irq_request,
	output ulmcs_pkg::ulmcs_fmt_t fmt,
	output logic [7:0] tx_data,
	output logic tx_write,
	output logic rx_read,
	output logic rx_store,
	output logic tx_resume,
	output logic baud_tick,
	output logic rx_serial,
	output logic ir_rx_to_dec,
	output logic modem_irq_req,
	output logic line_irq_req,
	// Line pins
	input wire logic [3:0] modem_in_n,
	input wire logic sin,
	input wire logic ir_rx,
	output ulmcs_pkg::ulmcs_pins_t pins
);
	import ulmcs_pkg::*;

	ulmcs_state_t s_reg;
	ulmcs_state_t s_next;
	ulmcs_sel_t sel;
	logic wr_acc;
	logic rd_acc;
	logic setup;
	logic loop_on;
	logic [3:0] modem_now;
	logic [3:0] delta_set;
	logic [7:0] line_status;
	logic [7:0] modem_status;
	logic overrun_evt;
	logic store_evt;

	// ========================================
	// Address decode, shared by the read mux and the write path.
	function automatic ulmcs_sel_t decode(input logic [7:0] addr, input logic dlab);
		ulmcs_sel_t r;
		r = SEL_NONE;
		case (addr)
			`ULMCS_OFS_DATA: r = dlab ? SEL_DLL : SEL_RXTX; // R3
			`ULMCS_OFS_IER: r = dlab ? SEL_DLM : SEL_IER; // R3
			`ULMCS_OFS_LCR: r = SEL_LCR;
			`ULMCS_OFS_MCR: r = SEL_MCR;
			`ULMCS_OFS_LSR: r = SEL_LSR;
			`ULMCS_OFS_MSR: r = SEL_MSR;
			`ULMCS_OFS_EFR: r = SEL_EFR;
			`ULMCS_OFS_FRAC: r = SEL_FRAC;
			default: r = SEL_NONE;
		endcase
		return r;
	endfunction : decode

	// ========================================
	// Bus handshake; a frozen block must not complete transfers it cannot act on.
	assign sel = decode(paddr, s_reg.line_control[`ULMCS_LCR_DLAB]);
	assign pready = ce;
	assign pslverr = psel & penable & (sel == SEL_NONE);
	assign setup = psel & ~penable & ~pwrite;
	assign wr_acc = ce & psel & penable & pwrite & (sel != SEL_NONE);
	assign rd_acc = ce & psel & penable & ~pwrite;

	// ========================================
	// Modem status view: control bits in loopback, inverted pins otherwise.
	assign loop_on = s_reg.modem_control[`ULMCS_MCR_LOOP];
	always_comb begin
		if (loop_on) begin
			modem_now = {s_reg.modem_control[`ULMCS_MCR_OUT2], s_reg.modem_control[`ULMCS_MCR_OUT1],
				s_reg.modem_control[`ULMCS_MCR_DTR], s_reg.modem_control[`ULMCS_MCR_RTS]}; // R23 R8
		end else begin
			modem_now = ~s_reg.modem_s2; // R24
		end
	end

	// Any change sets a delta, except ring which only marks the end of ringing.
	assign delta_set[0] = modem_now[0] ^ s_reg.modem_prev[0]; // R21
	assign delta_set[1] = modem_now[1] ^ s_reg.modem_prev[1]; // R21
	assign delta_set[2] = s_reg.modem_prev[2] & ~modem_now[2]; // R22
	assign delta_set[3] = modem_now[3] ^ s_reg.modem_prev[3]; // R21
	assign modem_status = {modem_now, s_reg.modem_delta};

	// ========================================
	// Receive events: overrun on a full FIFO, one break character per break.
	assign overrun_evt = core_st.rx_done & core_st.rx_fifo_full; // R14
	assign store_evt = core_st.rx_done & ~core_st.rx_fifo_full
		& ~(core_st.rx_is_break & s_reg.break_held) // R17
		& ~(core_st.rx_is_flow_char & s_reg.modem_control[`ULMCS_MCR_XANY]); // R9

	// Line status assembled from live datapath levels and the overrun flag.
	assign line_status = {
		core_st.fifo_err_any, // R20
		core_st.tx_hold_empty & core_st.tx_shift_empty, // R19
		core_st.tx_hold_empty, // R18
		core_st.head_break, // R17
		core_st.head_frame_err, // R16
		core_st.head_parity_err, // R15
		s_reg.overrun, // R14
		~core_st.rx_fifo_empty // R13
	};

	// ========================================
	// Next state.
	always_comb begin
		logic [7:0] wb;
		logic ir_on;
		logic lerr;
		wb = pwdata[7:0];
		ir_on = s_reg.modem_control[`ULMCS_MCR_IRDA] & s_reg.enhanced_feature_control[`ULMCS_EFR_ENH];
		lerr = core_st.rx_done & (core_st.head_parity_err | core_st.head_frame_err | core_st.rx_is_break);
		s_next = s_reg;
		s_next.tx_write = 1'b0;
		s_next.rx_read = 1'b0;

		// Register writes.
		if (wr_acc) begin
			case (sel)
				SEL_RXTX: begin
					s_next.tx_data = wb;
					s_next.tx_write = 1'b1;
				end
				SEL_IER: s_next.interrupt_enable_control = wb;
				SEL_DLL: s_next.divisor_low = wb; // R3
				SEL_DLM: s_next.divisor_high = wb; // R3
				SEL_LCR: s_next.line_control = wb;
				SEL_MCR: begin
					// Enhanced bits stay latched while the enhanced enable is clear.
					if (s_reg.enhanced_feature_control[`ULMCS_EFR_ENH]) begin
						s_next.modem_control = wb;
					end else begin
						s_next.modem_control = (s_reg.modem_control & `ULMCS_MCR_ENH_MASK)
							| (wb & ~`ULMCS_MCR_ENH_MASK); // R12
					end
				end
				SEL_EFR: s_next.enhanced_feature_control = wb;
				SEL_FRAC: begin
					if (s_reg.enhanced_feature_control[`ULMCS_EFR_ENH]) begin
						s_next.divisor_fraction = wb;
					end
				end
				default: s_next.tx_data = s_reg.tx_data;
			endcase
		end

		// Read data is captured in the setup cycle so it comes from a flip-flop.
		if (setup) begin
			case (sel)
				SEL_RXTX: s_next.prdata = {24'h000000, rx_head_data};
				SEL_IER: s_next.prdata = {24'h000000, s_reg.interrupt_enable_control};
				SEL_DLL: s_next.prdata = {24'h000000, s_reg.divisor_low};
				SEL_DLM: s_next.prdata = {24'h000000, s_reg.divisor_high};
				SEL_LCR: s_next.prdata = {24'h000000, s_reg.line_control};
				SEL_MCR: s_next.prdata = {24'h000000, s_reg.modem_control};
				SEL_LSR: s_next.prdata = {24'h000000, line_status};
				SEL_MSR: s_next.prdata = {24'h000000, modem_status};
				SEL_EFR: s_next.prdata = {24'h000000, s_reg.enhanced_feature_control};
				SEL_FRAC: s_next.prdata = {24'h000000, s_reg.divisor_fraction};
				default: s_next.prdata = 32'h00000000;
			endcase
		end
		if (rd_acc && sel == SEL_RXTX) begin
			s_next.rx_read = 1'b1;
		end

		// Synchronisers for the asynchronous pins.
		s_next.modem_s1 = modem_in_n;
		s_next.modem_s2 = s_reg.modem_s1;
		s_next.sin_s1 = {ir_rx, sin};
		s_next.sin_s2 = s_reg.sin_s1;

		// Delta flags: a read clears, a new change in the same cycle wins.
		s_next.modem_prev = modem_now;
		if (rd_acc && sel == SEL_MSR) begin
			s_next.modem_delta = 4'h0; // R27 R25
		end
		s_next.modem_delta = s_next.modem_delta | delta_set; // R21

		// Overrun and line status request: a read clears, a new event wins.
		if (rd_acc && sel == SEL_LSR) begin
			s_next.overrun = 1'b0; // R28
			s_next.ls_pending = 1'b0; // R26
		end
		if (overrun_evt) begin
			s_next.overrun = 1'b1; // R14
		end
		if (overrun_evt || lerr) begin
			s_next.ls_pending = 1'b1;
		end

		// Break character stored once; a normal character rearms it.
		if (core_st.rx_done) begin
			s_next.break_held = core_st.rx_is_break; // R17
		end
		s_next.rx_store = store_evt;
		s_next.tx_resume = core_st.rx_done & s_reg.modem_control[`ULMCS_MCR_XANY]; // R9

		// Prescaler: every cycle, or one in four when selected.
		if (s_reg.modem_control[`ULMCS_MCR_PRESC]) begin
			s_next.presc_cnt = 2'(s_reg.presc_cnt + 2'h1);
			s_next.baud_tick = (s_reg.presc_cnt == `ULMCS_PRESC_LAST); // R11
		end else begin
			s_next.presc_cnt = 2'h0;
			s_next.baud_tick = 1'b1; // R11
		end

		// Serial receive source: loopback, infrared decoder or plain pin.
		s_next.ir_rx_to_dec = s_reg.modem_control[`ULMCS_MCR_OUT1] ? s_reg.sin_s2[1] : ~s_reg.sin_s2[1]; // R6
		if (loop_on) begin
			s_next.rx_serial = tx_serial;
		end else if (ir_on) begin
			s_next.rx_serial = ir_rx_decoded; // R10
		end else begin
			s_next.rx_serial = s_reg.sin_s2[0];
		end

		// Serial transmit pins; break overrides both, loopback parks the line at mark.
		if (s_reg.line_control[`ULMCS_LCR_BREAK]) begin
			s_next.pins.sout = 1'b0; // R2
			s_next.pins.ir_tx = 1'b0; // R2
		end else begin
			s_next.pins.sout = loop_on | ir_on | tx_serial;
			s_next.pins.ir_tx = ir_on & ~loop_on & ir_tx_encoded; // R10
		end

		// Modem outputs are held inactive while looped back.
		s_next.pins.terminal_ready_n = loop_on | ~s_reg.modem_control[`ULMCS_MCR_DTR]; // R4
		if (s_reg.enhanced_feature_control[`ULMCS_EFR_ARTS]) begin
			s_next.pins.request_send_n = loop_on | auto_rts_n;
		end else begin
			s_next.pins.request_send_n = loop_on | ~s_reg.modem_control[`ULMCS_MCR_RTS]; // R5
		end
		s_next.pins.general_output_two_n = loop_on | ~s_reg.modem_control[`ULMCS_MCR_OUT2]; // R7
		s_next.pins.irq_oe = s_reg.modem_control[`ULMCS_MCR_OUT2]; // R7
		s_next.pins.irq_o = s_reg.modem_control[`ULMCS_MCR_OUT2] & irq_request; // R7
	end

	// ========================================
	// State register; the clock enable freezes everything.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.divisor_low <= `ULMCS_RST_DIV;
			s_reg.modem_s1 <= 4'hf;
			s_reg.modem_s2 <= 4'hf;
			s_reg.sin_s1 <= 2'h1;
			s_reg.sin_s2 <= 2'h1;
			s_reg.rx_serial <= 1'b1;
			s_reg.pins.sout <= 1'b1;
			s_reg.pins.terminal_ready_n <= 1'b1;
			s_reg.pins.request_send_n <= 1'b1;
			s_reg.pins.general_output_two_n <= 1'b1;
		end else if (ce) begin
			s_reg <= s_next;
		end
	end

	// ========================================
	// Outputs.
	assign prdata = s_reg.prdata;
	assign tx_data = s_reg.tx_data;
	assign tx_write = s_reg.tx_write;
	assign rx_read = s_reg.rx_read;
	assign rx_store = s_reg.rx_store;
	assign tx_resume = s_reg.tx_resume;
	assign baud_tick = s_reg.baud_tick;
	assign rx_serial = s_reg.rx_serial;
	assign ir_rx_to_dec = s_reg.ir_rx_to_dec;
	assign pins = s_reg.pins;
	assign modem_irq_req = s_reg.interrupt_enable_control[`ULMCS_IER_MS] & (|s_reg.modem_delta); // R21 R25
	assign line_irq_req = s_reg.interrupt_enable_control[`ULMCS_IER_LS] & s_reg.ls_pending; // R26

	// Format fields from the line control, divisor, modem control and enhanced feature registers.
	assign fmt.word_len = s_reg.line_control[1:0];
	assign fmt.stop_long = s_reg.line_control[2];
	assign fmt.parity_en = s_reg.line_control[`ULMCS_LCR_PEN];
	assign fmt.parity_forced = s_reg.line_control[`ULMCS_LCR_PEN] & s_reg.line_control[`ULMCS_LCR_FORCE]; // R1
	assign fmt.forced_value = ~s_reg.line_control[`ULMCS_LCR_EVEN]; // R1
	assign fmt.parity_even = s_reg.line_control[`ULMCS_LCR_EVEN];
	assign fmt.divisor = {s_reg.divisor_high, s_reg.divisor_low};
	assign fmt.divisor_fraction = s_reg.divisor_fraction;
	assign fmt.xon_any = s_reg.modem_control[`ULMCS_MCR_XANY]; // R9
	assign fmt.irda_en = s_reg.modem_control[`ULMCS_MCR_IRDA] & s_reg.enhanced_feature_control[`ULMCS_EFR_ENH];
	assign fmt.loopback = loop_on; // R8

endmodule : ulmcs_top
